// *** hw/bridge_command_exec_control.sv ***
`include "exec_ctrl_defs.svh"

module bridge_command_exec_control (
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire exec_ctrl_pkg::engine_fb_t fb,
    output exec_ctrl_pkg::issue_t          issue,
    output exec_ctrl_pkg::mode_t           mode,
    output logic                           pullup_abort,
    output logic                           flush_rx,
    output logic                           flush_tx,
    output logic                           result_valid,
    output logic                           fetch_short
);
    import exec_ctrl_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        exec_st_t              st;          // Execution state
        logic                  started;     // Start received
        logic                  halt_idle;   // Pending halt at bus idle
        logic                  halt_done;   // Pending halt at command end
        logic                  busy;        // A command is in the engine
        logic                  busy_macro;  // Its macro bit
        logic                  busy_ntf;    // Its notify bit
        mode_t                 mode;        // Mode settings
        logic [`CMDQ_AW-1:0]   rd;          // Queue read index
        logic [`CMDQ_AW-1:0]   wr;          // Queue write index
        logic [`FILL_W-1:0]    cnt;         // Queue fill
        logic [`CMDQ_DEPTH-1:0][7:0] q;     // Queue storage
        logic [15:0]           fetch_left;  // Bytes still requested
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
        issue_t                issue;
        logic                  abort;
        logic                  frx;
        logic                  ftx;
        logic                  res;
        logic                  short_pkt;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    logic          acc;      // Access phase of a transfer
    logic          wr_acc;   // Write access
    logic          halted;   // Engine halted
    logic [3:0]    cc;       // Control command code

    assign acc    = psel && penable && !s_r.pready;
    assign wr_acc = acc && pwrite;
    assign halted = (s_r.st == ST_HALTED);
    assign cc     = pwdata[3:0];

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_nxt           = s_r;
        // Pulses last one cycle
        s_nxt.pready    = 1'b0;
        s_nxt.pslverr   = 1'b0;
        s_nxt.issue     = '0;
        s_nxt.abort     = 1'b0;
        s_nxt.frx       = 1'b0;
        s_nxt.ftx       = 1'b0;
        s_nxt.res       = 1'b0;
        s_nxt.short_pkt = 1'b0;

        // Command completion from the engine
        if (s_r.busy && fb.done) begin
            s_nxt.busy = 1'b0;
            // Result only when macro clear and notify set
            s_nxt.res  = !s_r.busy_macro && s_r.busy_ntf;
            if (s_r.halt_done) begin
                s_nxt.st        = ST_HALTED;
                s_nxt.halt_done = 1'b0;
            end
        end

        // Halt at idle: stop once the bus settles
        if (s_r.halt_idle && fb.bus_idle) begin
            s_nxt.st        = ST_HALTED;
            s_nxt.halt_idle = 1'b0;
            s_nxt.busy      = 1'b0;
        end

        // Issue next queued byte; immediate bytes run before start.
        if (s_r.st != ST_HALTED && !s_r.busy && s_r.cnt != '0
            && !s_r.halt_idle && !s_r.halt_done) begin
            if (s_r.started || s_r.q[s_r.rd][`BIT_IMMEDIATE]) begin
                s_nxt.issue.valid    = 1'b1;
                s_nxt.issue.byte_val = s_r.q[s_r.rd];
                s_nxt.busy           = 1'b1;
                s_nxt.busy_macro     = s_r.q[s_r.rd][`BIT_MACRO];
                s_nxt.busy_ntf       = s_r.q[s_r.rd][`BIT_NOTIFY];
                s_nxt.rd             = s_r.rd + 1'b1;
                s_nxt.cnt            = s_r.cnt - 1'b1;
                s_nxt.st             = ST_RUN;
            end
        end

        // APB register access, one wait state
        if (acc) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = '0;
            case (paddr)
                `OFS_CTRL_CMD: begin
                    if (pwrite) begin
                        // Control commands act in this cycle
                        case (cc)
                            `CC_RESET: begin
                                s_nxt            = '0;
                                s_nxt.mode       = reset_mode();
                                s_nxt.st         = ST_IDLE;
                                s_nxt.frx        = 1'b1;
                                s_nxt.ftx        = 1'b1;
                                s_nxt.pready     = 1'b1;
                            end
                            `CC_START: begin
                                s_nxt.started = 1'b1;
                                if (s_r.st == ST_IDLE) begin
                                    s_nxt.st = ST_RUN;
                                end
                            end
                            `CC_RESUME: begin
                                if (halted) begin
                                    s_nxt.st = ST_RUN;
                                end
                            end
                            `CC_HALT_IDLE: begin
                                s_nxt.halt_idle = 1'b1;
                                s_nxt.abort     = 1'b1;
                            end
                            `CC_HALT_DONE: begin
                                s_nxt.abort = 1'b1;
                                // Next-state busy: a done in this cycle must not strand the halt
                                if (s_nxt.busy) begin
                                    s_nxt.halt_done = 1'b1;
                                end else begin
                                    s_nxt.st = ST_HALTED;
                                end
                            end
                            `CC_FLUSH_CMDS: begin
                                if (halted) begin
                                    s_nxt.rd  = '0;
                                    s_nxt.wr  = '0;
                                    s_nxt.cnt = '0;
                                end else begin
                                    s_nxt.pslverr = 1'b1;
                                end
                            end
                            `CC_FLUSH_RCV: begin
                                // Refused unless halted
                                s_nxt.frx     = halted;
                                s_nxt.pslverr = !halted;
                            end
                            `CC_FLUSH_XMT: begin
                                s_nxt.ftx     = halted;
                                s_nxt.pslverr = !halted;
                            end
                            default: begin
                                s_nxt.pslverr = 1'b1;
                            end
                        endcase
                    end
                end
                `OFS_MODE: begin
                    if (pwrite) begin
                        // Only host writes touch the mode
                        s_nxt.mode = unpack_mode(pwdata);
                    end
                    s_nxt.prdata = pack_mode(s_r.mode);
                end
                `OFS_STATUS: begin
                    s_nxt.prdata = {26'h0, s_r.halt_done, s_r.halt_idle,
                                    s_r.busy, s_r.started, s_r.st};
                end
                `OFS_FILL: begin
                    // Queue and data FIFO fill levels
                    s_nxt.prdata = {11'h0, fb.tx_fill, 3'h0, fb.rx_fill,
                                    3'h0, s_r.cnt};
                end
                `OFS_CMD_PUSH: begin
                    if (pwrite) begin
                        if (s_r.cnt != 5'(`CMDQ_DEPTH)) begin
                            s_nxt.q[s_r.wr] = pwdata[7:0];
                            s_nxt.wr        = s_r.wr + 1'b1;
                            s_nxt.cnt       = s_nxt.cnt + 1'b1;
                        end else begin
                            s_nxt.pslverr = 1'b1; // Full: dropped
                        end
                    end
                end
                `OFS_FETCH_LEN: begin
                    // Host supplies the wanted length
                    if (pwrite) begin
                        if (halted) begin
                            s_nxt.fetch_left = pwdata[15:0];
                        end else begin
                            s_nxt.pslverr = 1'b1;
                        end
                    end
                    s_nxt.prdata = {16'h0, s_r.fetch_left};
                end
                `OFS_FETCH_DATA: begin
                    if (!pwrite && halted && s_r.fetch_left != '0) begin
                        if (s_r.cnt != '0) begin
                            // Byte leaves the queue as it is read
                            s_nxt.prdata     = {24'h0, s_r.q[s_r.rd]};
                            s_nxt.rd         = s_r.rd + 1'b1;
                            s_nxt.cnt        = s_r.cnt - 1'b1;
                            s_nxt.fetch_left = s_r.fetch_left - 1'b1;
                        end else begin
                            // Queue ran dry before the length
                            s_nxt.short_pkt  = 1'b1;
                            s_nxt.fetch_left = '0;
                            s_nxt.prdata     = 32'h0000_0100;
                        end
                    end else if (pwrite || !halted) begin
                        s_nxt.pslverr = 1'b1;
                    end
                end
                `OFS_DONE: begin
                    s_nxt.prdata = {31'h0, s_r.res};
                end
                default: begin
                    s_nxt.pslverr = 1'b1; // Unmapped address
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Mode helpers
    // ------------------------------------------------------------
    function automatic mode_t reset_mode();
        // Fields in struct order
        return {`RST_PULSE_EN, `RST_SPDCHG_EN, `RST_SPEED,
                `RST_DURATION,
                `RST_SLEW, `RST_W1LT, `RST_DSO};
    endfunction

    function automatic mode_t unpack_mode(input logic [31:0] d);
        return {d[`MODE_PULSE_BIT], d[`MODE_SPDCHG_BIT], d[`MODE_SPEED_LSB +: 3],
                d[`MODE_DUR_LSB +: 8], d[`MODE_SLEW_LSB +: 3], d[`MODE_W1LT_LSB +: 3],
                d[`MODE_DSO_LSB +: 3]};
    endfunction

    function automatic logic [31:0] pack_mode(input mode_t m);
        logic [31:0] d;
        d                        = '0;
        d[`MODE_PULSE_BIT]       = m.pulse_en;
        d[`MODE_SPDCHG_BIT]      = m.speed_chg_en;
        d[`MODE_SPEED_LSB +: 3]  = m.speed;
        d[`MODE_DUR_LSB +: 8]    = m.duration;
        d[`MODE_SLEW_LSB +: 3]   = m.slew;
        d[`MODE_W1LT_LSB +: 3]   = m.write1_low;
        d[`MODE_DSO_LSB +: 3]    = m.sample_offset_recovery_time;
        return d;
    endfunction

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_r      <= '0;
            s_r.mode <= reset_mode();
            s_r.st   <= ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state flops
    assign prdata       = s_r.prdata;
    assign pready       = s_r.pready;
    assign pslverr      = s_r.pslverr;
    assign issue        = s_r.issue;
    assign mode         = s_r.mode;
    assign pullup_abort = s_r.abort;
    assign flush_rx     = s_r.frx;
    assign flush_tx     = s_r.ftx;
    assign result_valid = s_r.res;
    assign fetch_short  = s_r.short_pkt;
endmodule

// *** common/exec_ctrl_defs.svh ***
`ifndef EXEC_CTRL_DEFS_SVH
`define EXEC_CTRL_DEFS_SVH
// Function
// - Power-on: pullup off, speed change off, regular
// - Power-on pullup duration code is 0x20
// - Power-on slew 0x5, write-one 0x4, recovery 0x4
// - Mode settings change only by host command
// - Control commands act immediately, never queued
// - Device reset equals power-on reset, and also pulses both data FIFO flushes
// - Start enables queued non-immediate command execution
// - Resume restarts processing after either halt
// - Halt-idle stops current command at bus idle
// - Halt-done lets current command finish, then stops
// - Either halt ends infinite strong pullup
// - Flush commands empties command FIFO while halted
// - Flush receive empties receive FIFO while halted
// - Flush transmit empties transmit FIFO while halted
// - Fetch returns queued bytes only while halted
// - Each fetched byte leaves the command FIFO
// - Unfetched bytes stay queued for later execution
// - Short packet when request exceeds queued bytes
// - Macro bit suppresses the result of its command
// - Result depends on macro and notify bits
// - Command and data FIFO fill readable by host

// ----------
// Register offsets (byte addresses)
// ----------
`define OFS_CTRL_CMD     12'h000
`define OFS_MODE         12'h004
`define OFS_STATUS       12'h008
`define OFS_FILL         12'h00c
`define OFS_CMD_PUSH     12'h010
`define OFS_FETCH_LEN    12'h014
`define OFS_FETCH_DATA   12'h018
`define OFS_DONE         12'h01c

// ----------
// Control command codes written to OFS_CTRL_CMD
// ----------
`define CC_RESET         4'h0
`define CC_START         4'h1
`define CC_RESUME        4'h2
`define CC_HALT_IDLE     4'h3
`define CC_HALT_DONE     4'h4
`define CC_FLUSH_CMDS    4'h5
`define CC_FLUSH_RCV     4'h6
`define CC_FLUSH_XMT     4'h7
`define CC_FETCH         4'h8

// ----------
// Mode register field positions
// ----------
`define MODE_PULSE_BIT   0
`define MODE_SPDCHG_BIT  1
`define MODE_SPEED_LSB   4
`define MODE_DUR_LSB     8
`define MODE_SLEW_LSB    16
`define MODE_W1LT_LSB    20
`define MODE_DSO_LSB     24

// ----------
// Power-on mode values
// ----------
`define RST_PULSE_EN     1'b0
`define RST_SPDCHG_EN    1'b0
`define RST_SPEED        3'h0
`define RST_DURATION     8'h20
`define RST_SLEW         3'h5
`define RST_W1LT         3'h4
`define RST_DSO          3'h4

// ----------
// Command byte bits and FIFO sizing
// ----------
`define BIT_IMMEDIATE    0
`define BIT_MACRO        1
`define BIT_NOTIFY       2
`define CMDQ_DEPTH       16
`define CMDQ_AW          4
`define FILL_W           5
`endif

// *** common/exec_ctrl_pkg.sv ***
package exec_ctrl_pkg;
    // Mode settings held for the bus engine
    typedef struct packed {
        logic       pulse_en;
        logic       speed_chg_en;
        logic [2:0] speed;
        logic [7:0] duration;
        logic [2:0] slew;
        logic [2:0] write1_low;
        logic [2:0] sample_offset_recovery_time;
    } mode_t;

    // Engine execution states
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_RUN    = 2'b01,
        ST_HALTED = 2'b10
    } exec_st_t;

    // Command handed to the bus engine
    typedef struct packed {
        logic       valid;
        logic [7:0] byte_val;
    } issue_t;

    // Engine feedback
    typedef struct packed {
        logic       done;
        logic       bus_idle;
        logic [4:0] rx_fill;
        logic [4:0] tx_fill;
    } engine_fb_t;
endpackage

// *** testbench/exec_ctrl_checker.sv ***
`include "exec_ctrl_defs.svh"
// ------------------------------------------------------------
// Port-level checks
// ------------------------------------------------------------
module exec_ctrl_checker (
    input wire logic                      clk,
    input wire logic                      rstn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [11:0]               paddr,
    input wire logic [31:0]               pwdata,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    input wire exec_ctrl_pkg::engine_fb_t fb,
    input wire exec_ctrl_pkg::issue_t     issue,
    input wire exec_ctrl_pkg::mode_t      mode,
    input wire logic                      pullup_abort,
    input wire logic                      flush_rx,
    input wire logic                      flush_tx,
    input wire logic                      result_valid,
    input wire logic                      fetch_short
);
    import exec_ctrl_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic       ctl_acc; // Control write in its access phase
    logic [3:0] code;    // Control code carried by that write
    mode_t      dflt;    // Power-on mode image
    assign ctl_acc = psel && penable && pwrite && paddr == `OFS_CTRL_CMD;
    assign code = pwdata[3:0];
    assign dflt = {`RST_PULSE_EN, `RST_SPDCHG_EN, `RST_SPEED, `RST_DURATION,
                   `RST_SLEW, `RST_W1LT, `RST_DSO};
    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after one wait state");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // ------------------------------------------------------------
    // Mode settings
    // ------------------------------------------------------------
    a_reset_mode: assert property ($rose(rstn) |-> mode == dflt)
        else $error("mode not at defaults after reset");
    a_mode_cause: assert property (!$stable(mode) |-> $past(psel && pwrite))
        else $error("mode changed without a host write");
    a_ctl_reset: assert property (ctl_acc && !pready && code == `CC_RESET |=> mode == dflt)
        else $error("control reset left mode altered");
    // ------------------------------------------------------------
    // Side effects of control commands, fetch, issue and result
    // ------------------------------------------------------------
    a_abort_cause: assert property (pullup_abort |->
        $past(ctl_acc && (code == `CC_HALT_IDLE || code == `CC_HALT_DONE)))
        else $error("pullup abort without a halt");
    a_rx_cause: assert property (flush_rx |->
        $past(ctl_acc && (code == `CC_FLUSH_RCV || code == `CC_RESET)))
        else $error("receive flush without command");
    a_tx_cause: assert property (flush_tx |->
        $past(ctl_acc && (code == `CC_FLUSH_XMT || code == `CC_RESET)))
        else $error("transmit flush without command");
    a_short_data: assert property (fetch_short |-> pready && prdata == 32'h0000_0100)
        else $error("short marker not on read data");
    a_issue_single: assert property (issue.valid |=> !issue.valid)
        else $error("two issues back to back");
    a_result_cause: assert property (result_valid |-> $past(fb.done) || $past(fb.done, 2))
        else $error("result without finished command");
    c_short: cover property (fetch_short);
    c_abort: cover property (pullup_abort);
    c_result: cover property (result_valid);
endmodule

bind bridge_command_exec_control exec_ctrl_checker chk_i (.*);

// *** testbench/engine_model.sv ***
// ------------------------------------------------------------
// Bus engine stand-in: runs one command, then pulses done
// ------------------------------------------------------------
module engine_model (
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire logic                      slow,
    input  wire exec_ctrl_pkg::issue_t     issue,
    input  wire logic                      flush_rx,
    input  wire logic                      flush_tx,
    output exec_ctrl_pkg::engine_fb_t      fb
);
    import exec_ctrl_pkg::*;
    logic [3:0] cnt_r; // Cycles left on the bus
    // Slow mode stretches each command to test waiting
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_r <= 4'h0;
            fb <= '{done: 1'b0, bus_idle: 1'b1, rx_fill: 5'h03, tx_fill: 5'h07};
        end else begin
            fb.done <= 1'b0;
            fb.bus_idle <= !(issue.valid || cnt_r > 4'h1);
            if (issue.valid) begin
                cnt_r <= slow ? 4'h6 : 4'h1;
            end else if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
                fb.done <= (cnt_r == 4'h1);
                // Each finished command leaves a byte to read
                if (cnt_r == 4'h1) begin
                    fb.rx_fill <= fb.rx_fill + 5'h01;
                end
            end
            if (flush_rx) begin
                fb.rx_fill <= 5'h00;
            end
            if (flush_tx) begin
                fb.tx_fill <= 5'h00;
            end
        end
    end
endmodule

// *** testbench/tb.sv ***
`include "exec_ctrl_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import exec_ctrl_pkg::*;
    logic        clk, rstn, psel, penable, pwrite, slow, pready, pslverr, err;
    logic        pullup_abort, flush_rx, flush_tx, result_valid, fetch_short;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  last_iss;
    engine_fb_t  fb;
    issue_t      issue;
    mode_t       mode;
    int          err_count, checks, n_iss, n_done, n_res, n_abt, n_frx, n_ftx, n_sht;

    bridge_command_exec_control uut (.*);
    engine_model eng (.*);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ----------
    // Pulse counters; pulses last one cycle so count every edge
    // ----------
    always @(posedge clk) begin
        if (issue.valid === 1'b1) begin
            n_iss++;
            last_iss = issue.byte_val;
        end
        if (fb.done === 1'b1) n_done++;
        if (result_valid === 1'b1) n_res++;
        if (pullup_abort === 1'b1) n_abt++;
        if (flush_rx === 1'b1) n_frx++;
        if (flush_tx === 1'b1) n_ftx++;
        if (fetch_short === 1'b1) n_sht++;
    end
    // ----------
    // Shared helpers
    // ----------
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; holds everything until pready is seen
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk("pready", 32'h0, 32'h1);
    endtask
    // Bounded wait on a counter, then a short settle
    task automatic wait_cnt(ref int c, input int t);
        int n;
        n = 0;
        while (c < t && n < 200) begin
            @(posedge clk);
            n++;
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic ctl(logic [3:0] c);
        apb(1'b1, `OFS_CTRL_CMD, {28'h0, c});
    endtask
    // ----------
    // Scenarios
    // ----------
    task automatic t_defaults;
        apb(1'b0, `OFS_MODE, 32'h0);
        chk("mode reg", rd, 32'h0445_2000);
        chk("mode port", {10'h0, mode}, 32'h0000_4164);
        apb(1'b1, `OFS_MODE, 32'h0761_0023);
        apb(1'b0, `OFS_MODE, 32'h0);
        chk("mode back", rd, 32'h0761_0023);
        chk("dur port", {24'h0, mode.duration}, 32'h0);
        $display("t_defaults done");
    endtask
    task automatic t_exec;
        // Immediate byte runs before start; a non-immediate byte waits for start
        apb(1'b1, `OFS_CMD_PUSH, 32'h05);
        wait_cnt(n_done, 1);
        chk("imm byte", {24'h0, last_iss}, 32'h05);
        apb(1'b1, `OFS_CMD_PUSH, 32'h04);
        repeat (20) @(posedge clk);
        chk("held issue", n_iss, 32'h1);
        ctl(`CC_START);
        wait_cnt(n_done, 2);
        chk("start byte", {24'h0, last_iss}, 32'h04);
        chk("results", n_res, 32'h2);
        slow <= 1'b1;
        apb(1'b1, `OFS_CMD_PUSH, 32'h06);
        wait_cnt(n_done, 3);
        chk("macro issue", n_iss, 32'h3);
        chk("macro result", n_res, 32'h2);
        apb(1'b0, `OFS_MODE, 32'h0);
        chk("mode kept", rd, 32'h0761_0023);
        $display("t_exec done");
    endtask
    task automatic t_halt_fetch;
        ctl(`CC_HALT_DONE);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("halt state", {30'h0, rd[1:0]}, 32'h2);
        chk("abort", n_abt, 32'h1);
        for (int i = 0; i < 3; i++) apb(1'b1, `OFS_CMD_PUSH, 32'h10 + 32'(2 * i));
        repeat (5) @(posedge clk);
        chk("halted issue", n_iss, 32'h3);
        apb(1'b0, `OFS_FILL, 32'h0);
        chk("cmd fill", {27'h0, rd[4:0]}, 32'h3);
        apb(1'b1, `OFS_FETCH_LEN, 32'h2);
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, `OFS_FETCH_DATA, 32'h0);
            chk("fetched", rd, 32'h10 + 32'(2 * i));
        end
        apb(1'b0, `OFS_FILL, 32'h0);
        chk("left fill", {27'h0, rd[4:0]}, 32'h1);
        ctl(`CC_RESUME);
        wait_cnt(n_done, 4);
        chk("resumed byte", {24'h0, last_iss}, 32'h14);
        $display("t_halt_fetch done");
    endtask
    task automatic t_flush;
        ctl(`CC_FLUSH_CMDS);
        chk("flush running", {31'h0, err}, 32'h1);
        apb(1'b1, `OFS_FETCH_LEN, 32'h1);
        chk("fetch running", {31'h0, err}, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        ctl(`CC_HALT_IDLE);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("idle halt", {30'h0, rd[1:0]}, 32'h2);
        chk("abort", n_abt, 32'h2);
        apb(1'b1, `OFS_CMD_PUSH, 32'h20);
        ctl(`CC_FLUSH_CMDS);
        chk("flush ok", {31'h0, err}, 32'h0);
        apb(1'b1, `OFS_FETCH_LEN, 32'h1);
        apb(1'b0, `OFS_FETCH_DATA, 32'h0);
        chk("short data", rd, 32'h0000_0100);
        @(negedge clk);
        chk("short", n_sht, 32'h1);
        ctl(`CC_FLUSH_RCV);
        ctl(`CC_FLUSH_XMT);
        @(negedge clk);
        chk("rx pulse", n_frx, 32'h1);
        chk("tx pulse", n_ftx, 32'h1);
        apb(1'b0, `OFS_FILL, 32'h0);
        chk("data fill", {22'h0, rd[20:16], rd[12:8]}, 32'h0);
        $display("t_flush done");
    endtask
    task automatic t_ctl_reset;
        ctl(`CC_RESET);
        apb(1'b0, `OFS_MODE, 32'h0);
        chk("mode reload", rd, 32'h0445_2000);
        chk("reset flush", n_frx + n_ftx, 32'h4);
        apb(1'b1, `OFS_CMD_PUSH, 32'h08);
        repeat (20) @(posedge clk);
        chk("start cleared", n_iss, 32'h4);
        $display("t_ctl_reset done");
    endtask
    // ----------
    // Verdict, watchdog and main sequence
    // ----------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Tests need a few hundred cycles; this margin is generous
    initial begin
        repeat (20000) @(posedge clk);
        chk("watchdog", 32'h1, 32'h0);
        complete_run;
    end
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        slow = 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_defaults;
        t_exec;
        t_halt_fetch;
        t_flush;
        t_ctl_reset;
        complete_run;
    end
endmodule
